// ==== logic/pinc_pkg.sv ====
// Package for the peripheral interrupt priority and control block
package pinc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_PRIO_A = 4'h0;
    localparam logic [3:0] ADDR_PRIO_B = 4'h1;
    localparam logic [3:0] ADDR_PRIO_C = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam logic [3:0] ADDR_EVENT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    // Reset values
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Writable masks
    localparam logic [15:0] PRIO_A_MASK = 16'hffff;
    localparam logic [15:0] PRIO_B_MASK = 16'hfff0;
    localparam logic [15:0] PRIO_C_MASK = 16'hffff;
    localparam logic [15:0] CTRL_WMASK = 16'h4380;
    // Control field positions
    localparam int CTRL_PIN_LEVEL = 15;
    localparam int CTRL_LOW_MASK = 14;
    localparam int CTRL_BLOCK_MODE = 9;
    localparam int CTRL_EDGE_SEL = 8;
    localparam int CTRL_PIN_MODE = 7;
    // Priority field positions (low bit of each nibble)
    localparam int FLD_HI = 12;
    localparam int FLD_MH = 8;
    localparam int FLD_ML = 4;
    localparam int FLD_LO = 0;
    // Source index into the request vector, in default order
    localparam int SRC_ALARM = 0;
    localparam int SRC_PERIODIC = 1;
    localparam int SRC_CARRY = 2;
    localparam int SRC_S1_RXERR = 3;
    localparam int SRC_S1_RXFULL = 4;
    localparam int SRC_S1_TXEMPTY = 5;
    localparam int SRC_S1_TXEND = 6;
    localparam int SRC_F_RXERR = 7;
    localparam int SRC_F_RXFULL = 8;
    localparam int SRC_F_BREAK = 9;
    localparam int SRC_F_TXEMPTY = 10;
    localparam int SRC_WDOG = 11;
    localparam int SRC_REF_CMP = 12;
    localparam int SRC_REF_OVF = 13;
    localparam int NUM_SRC = 14;
    // Event codes
    localparam logic [11:0] EVT_NMI = 12'h1c0;
    localparam logic [11:0] EVT_ALARM = 12'h480;
    localparam logic [11:0] EVT_PERIODIC = 12'h4a0;
    localparam logic [11:0] EVT_CARRY = 12'h4c0;
    localparam logic [11:0] EVT_S1_RXERR = 12'h4e0;
    localparam logic [11:0] EVT_S1_RXFULL = 12'h500;
    localparam logic [11:0] EVT_S1_TXEMPTY = 12'h520;
    localparam logic [11:0] EVT_S1_TXEND = 12'h540;
    localparam logic [11:0] EVT_WDOG = 12'h560;
    localparam logic [11:0] EVT_REF_CMP = 12'h580;
    localparam logic [11:0] EVT_REF_OVF = 12'h5a0;
    localparam logic [11:0] EVT_F_RXERR = 12'h700;
    localparam logic [11:0] EVT_F_RXFULL = 12'h720;
    localparam logic [11:0] EVT_F_BREAK = 12'h740;
    localparam logic [11:0] EVT_F_TXEMPTY = 12'h760;
    localparam logic [4:0] NMI_LEVEL = 5'h10;

    // Request offered to the CPU
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [3:0] level;
        logic [11:0] code;
    } pinc_req_t;

    // Plain register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } pinc_bus_t;
endpackage : pinc_pkg

// ==== logic/pinc_regs.sv ====
// Register store: three priority registers and the writable control bits
`timescale 1ns/100ps
module pinc_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire pinc_pkg::pinc_bus_t bus_i,
    input wire logic nmi_accept_i,
    output logic [15:0] prio_a_o,
    output logic [15:0] prio_b_o,
    output logic [15:0] prio_c_o,
    output logic [15:0] ctrl_o
);
    // Priority registers, cleared by reset, masked reserved bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prio_a_o <= pinc_pkg::PRIO_RESET;
            prio_b_o <= pinc_pkg::PRIO_RESET;
            prio_c_o <= pinc_pkg::PRIO_RESET;
        end else if (bus_i.wr) begin
            if (bus_i.addr == pinc_pkg::ADDR_PRIO_A) begin
                prio_a_o <= bus_i.wdata & pinc_pkg::PRIO_A_MASK;
            end else if (bus_i.addr == pinc_pkg::ADDR_PRIO_B) begin
                prio_b_o <= bus_i.wdata & pinc_pkg::PRIO_B_MASK;
            end else if (bus_i.addr == pinc_pkg::ADDR_PRIO_C) begin
                prio_c_o <= bus_i.wdata & pinc_pkg::PRIO_C_MASK;
            end
        end
    end

    // Control bits; acceptance of an NMI clears block mode and wins over a write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_o <= pinc_pkg::CTRL_RESET;
        end else begin
            if (bus_i.wr && bus_i.addr == pinc_pkg::ADDR_CTRL) begin
                ctrl_o <= bus_i.wdata & pinc_pkg::CTRL_WMASK;
            end
            if (nmi_accept_i) begin
                ctrl_o[pinc_pkg::CTRL_BLOCK_MODE] <= 1'b0;
            end
        end
    end
endmodule : pinc_regs

// ==== logic/pinc_top.sv ====
// Priority arbiter and control for on-chip peripheral interrupts
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module pinc_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic nmi_pin_i,
    input wire logic [13:0] src_req_i,
    input wire logic [3:0] cpu_mask_level_i,
    input wire logic cpu_block_bit_i,
    input wire logic standby_i,
    input wire logic cpu_accept_i,
    output logic irq_valid_o,
    output logic irq_nmi_o,
    output logic [3:0] irq_level_o,
    output logic [11:0] irq_code_o,
    output logic request_pin_mode_o,
    output logic wake_o
);
    pinc_pkg::pinc_bus_t bus;
    pinc_pkg::pinc_req_t next_req;
    pinc_pkg::pinc_req_t req;
    logic [15:0] prio_a;
    logic [15:0] prio_b;
    logic [15:0] prio_c;
    logic [15:0] ctrl;
    logic [11:0] event_code_register;
    logic pin_prev;
    logic nmi_pending;
    logic nmi_edge;
    logic nmi_accept;
    logic low_block;
    logic nmi_allowed;
    logic [3:0] src_level [pinc_pkg::NUM_SRC];
    logic [11:0] src_code [pinc_pkg::NUM_SRC];

    // Nibble of a priority register
    function automatic logic [3:0] nib(input logic [15:0] r, input int lo);
        nib = r[lo +: 4];
    endfunction : nib

    assign bus = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

    pinc_regs u_regs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus_i(bus),
        .nmi_accept_i(nmi_accept),
        .prio_a_o(prio_a),
        .prio_b_o(prio_b),
        .prio_c_o(prio_c),
        .ctrl_o(ctrl)
    );

    // Per-source level and code table, in default order
    always_comb begin
        src_level[pinc_pkg::SRC_ALARM] = nib(prio_a, pinc_pkg::FLD_LO);
        src_level[pinc_pkg::SRC_PERIODIC] = nib(prio_a, pinc_pkg::FLD_LO);
        src_level[pinc_pkg::SRC_CARRY] = nib(prio_a, pinc_pkg::FLD_LO);
        src_level[pinc_pkg::SRC_S1_RXERR] = nib(prio_b, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_S1_RXFULL] = nib(prio_b, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_S1_TXEMPTY] = nib(prio_b, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_S1_TXEND] = nib(prio_b, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_F_RXERR] = nib(prio_c, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_F_RXFULL] = nib(prio_c, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_F_BREAK] = nib(prio_c, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_F_TXEMPTY] = nib(prio_c, pinc_pkg::FLD_ML);
        src_level[pinc_pkg::SRC_WDOG] = nib(prio_b, pinc_pkg::FLD_HI);
        src_level[pinc_pkg::SRC_REF_CMP] = nib(prio_b, pinc_pkg::FLD_MH);
        src_level[pinc_pkg::SRC_REF_OVF] = nib(prio_b, pinc_pkg::FLD_MH);
        src_code[pinc_pkg::SRC_ALARM] = pinc_pkg::EVT_ALARM;
        src_code[pinc_pkg::SRC_PERIODIC] = pinc_pkg::EVT_PERIODIC;
        src_code[pinc_pkg::SRC_CARRY] = pinc_pkg::EVT_CARRY;
        src_code[pinc_pkg::SRC_S1_RXERR] = pinc_pkg::EVT_S1_RXERR;
        src_code[pinc_pkg::SRC_S1_RXFULL] = pinc_pkg::EVT_S1_RXFULL;
        src_code[pinc_pkg::SRC_S1_TXEMPTY] = pinc_pkg::EVT_S1_TXEMPTY;
        src_code[pinc_pkg::SRC_S1_TXEND] = pinc_pkg::EVT_S1_TXEND;
        src_code[pinc_pkg::SRC_F_RXERR] = pinc_pkg::EVT_F_RXERR;
        src_code[pinc_pkg::SRC_F_RXFULL] = pinc_pkg::EVT_F_RXFULL;
        src_code[pinc_pkg::SRC_F_BREAK] = pinc_pkg::EVT_F_BREAK;
        src_code[pinc_pkg::SRC_F_TXEMPTY] = pinc_pkg::EVT_F_TXEMPTY;
        src_code[pinc_pkg::SRC_WDOG] = pinc_pkg::EVT_WDOG;
        src_code[pinc_pkg::SRC_REF_CMP] = pinc_pkg::EVT_REF_CMP;
        src_code[pinc_pkg::SRC_REF_OVF] = pinc_pkg::EVT_REF_OVF;
    end

    // Maskable requests blocked while pin low and low mask set
    assign low_block = ctrl[pinc_pkg::CTRL_LOW_MASK] && !nmi_pin_i;
    // NMI edge per selected polarity
    assign nmi_edge = ctrl[pinc_pkg::CTRL_EDGE_SEL] ? (nmi_pin_i && !pin_prev)
                                                   : (!nmi_pin_i && pin_prev);
    // NMI goes out unless held by block bit, and never in standby under low mask
    assign nmi_allowed = (!cpu_block_bit_i || ctrl[pinc_pkg::CTRL_BLOCK_MODE])
                         && !(standby_i && ctrl[pinc_pkg::CTRL_LOW_MASK]);
    assign nmi_accept = req.valid && req.nmi && cpu_accept_i;

    // Pin history for edge detection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= nmi_pin_i;
        end
    end

    // Pending NMI; a new edge wins over the clear on acceptance
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_pending <= 1'b0;
        end else if (nmi_edge && !(standby_i && ctrl[pinc_pkg::CTRL_LOW_MASK])) begin
            nmi_pending <= 1'b1;
        end else if (nmi_accept) begin
            nmi_pending <= 1'b0;
        end
    end

    // Arbitration: highest level, ties by default order (lower index first)
    always_comb begin
        next_req = '0;
        if (nmi_pending && nmi_allowed) begin
            next_req.valid = 1'b1;
            next_req.nmi = 1'b1;
            next_req.level = 4'hf;
            next_req.code = pinc_pkg::EVT_NMI;
        end else if (!low_block && !standby_i && !cpu_block_bit_i) begin
            for (int i = 0; i < pinc_pkg::NUM_SRC; i++) begin
                if (src_req_i[i] && src_level[i] != 4'h0
                    && src_level[i] > next_req.level) begin
                    next_req.level = src_level[i];
                    next_req.code = src_code[i];
                end
            end
            next_req.valid = next_req.level > cpu_mask_level_i;
            if (!next_req.valid) begin
                next_req.level = 4'h0;
                next_req.code = 12'h000;
            end
        end
    end

    // Request register toward the CPU; fields move together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req <= '0;
        end else if (cpu_accept_i && req.valid) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    assign irq_valid_o = req.valid;
    assign irq_nmi_o = req.nmi;
    assign irq_level_o = req.level;
    assign irq_code_o = req.code;

    // Event register loaded on acceptance
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_code_register <= 12'h000;
        end else if (cpu_accept_i && req.valid) begin
            event_code_register <= req.code;
        end
    end

    // Status outputs: pin mode and standby wake
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            request_pin_mode_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            request_pin_mode_o <= ctrl[pinc_pkg::CTRL_PIN_MODE];
            wake_o <= standby_i && nmi_pending && !ctrl[pinc_pkg::CTRL_LOW_MASK];
        end
    end

    // Read data one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == pinc_pkg::ADDR_PRIO_A) begin
                reg_rdata_o <= prio_a;
            end else if (reg_addr_i == pinc_pkg::ADDR_PRIO_B) begin
                reg_rdata_o <= prio_b;
            end else if (reg_addr_i == pinc_pkg::ADDR_PRIO_C) begin
                reg_rdata_o <= prio_c;
            end else if (reg_addr_i == pinc_pkg::ADDR_CTRL) begin
                reg_rdata_o <= {nmi_pin_i, ctrl[14:0]};
            end else if (reg_addr_i == pinc_pkg::ADDR_EVENT) begin
                reg_rdata_o <= {4'h0, event_code_register};
            end else if (reg_addr_i == pinc_pkg::ADDR_STATUS) begin
                reg_rdata_o <= {15'h0000, nmi_pending};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end
endmodule : pinc_top

// ==== verification/pinc_cpu_model.sv ====
// CPU core model that takes offered interrupt requests
`timescale 1ns/100ps
module pinc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire logic [3:0] wait_i,
    output logic accept_o
);
    logic [3:0] cnt;
    // One-cycle accept after wait_i cycles of a standing offer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            accept_o <= 1'b0;
        end else begin
            accept_o <= valid_i && !accept_o && cnt >= wait_i;
            cnt <= (valid_i && !accept_o) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule : pinc_cpu_model

// ==== verification/pinc_top_sva.sv ====
// Port assertions for the interrupt priority block
`timescale 1ns/100ps
module pinc_top_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic nmi_pin_i,
    input wire logic [13:0] src_req_i,
    input wire logic [3:0] cpu_mask_level_i,
    input wire logic cpu_block_bit_i,
    input wire logic standby_i,
    input wire logic cpu_accept_i,
    input wire logic irq_valid_o,
    input wire logic irq_nmi_o,
    input wire logic [3:0] irq_level_o,
    input wire logic [11:0] irq_code_o,
    input wire logic request_pin_mode_o,
    input wire logic wake_o
);
    logic [15:0] ctrl_sh;
    logic [11:0] last_code;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of writable control bits; accept clears block mode last
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_sh <= 16'h0000;
        end else begin
            if (reg_wr_i && reg_addr_i == pinc_pkg::ADDR_CTRL) begin
                ctrl_sh <= reg_wdata_i & pinc_pkg::CTRL_WMASK;
            end
            if (cpu_accept_i && irq_valid_o && irq_nmi_o) begin
                ctrl_sh[pinc_pkg::CTRL_BLOCK_MODE] <= 1'b0;
            end
        end
    end
    // Code of the last accepted request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_code <= 12'h000;
        end else if (cpu_accept_i && irq_valid_o) begin
            last_code <= irq_code_o;
        end
    end
    sequence taken;
        cpu_accept_i && irq_valid_o;
    endsequence
    sequence nmi_edge;
        (!ctrl_sh[8] && $fell(nmi_pin_i)) || (ctrl_sh[8] && $rose(nmi_pin_i));
    endsequence
    sequence ctrl_rd;
        reg_rd_i && reg_addr_i == pinc_pkg::ADDR_CTRL;
    endsequence
    a_idle_rdata: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero when idle");
    a_ctrl_read: assert property (ctrl_rd |=> reg_rdata_o == {$past(nmi_pin_i), $past(ctrl_sh[14:0])})
        else $error("control read wrong");
    a_prio_res: assert property (reg_rd_i && reg_addr_i == pinc_pkg::ADDR_PRIO_B |=> reg_rdata_o[3:0] == 4'h0)
        else $error("reserved nibble not zero");
    a_event_read: assert property (reg_rd_i && reg_addr_i == pinc_pkg::ADDR_EVENT |=> reg_rdata_o == {4'h0, $past(last_code)})
        else $error("event register wrong");
    a_mask_cmp: assert property (irq_valid_o && !irq_nmi_o |-> irq_level_o > $past(cpu_mask_level_i))
        else $error("request not above mask");
    a_nmi_group: assert property (irq_valid_o && irq_nmi_o |-> irq_level_o == 4'hf && irq_code_o == pinc_pkg::EVT_NMI)
        else $error("nmi level or code wrong");
    a_accept_drop: assert property (taken |=> !irq_valid_o)
        else $error("request stays after accept");
    a_low_mask: assert property (ctrl_sh[14] && !nmi_pin_i |=> !irq_valid_o || irq_nmi_o)
        else $error("maskable passed with pin low");
    a_block_hold: assert property (cpu_block_bit_i && !ctrl_sh[9] |=> !irq_valid_o)
        else $error("request passed under block");
    a_nmi_edge: assert property (nmi_edge ##0 (!standby_i && (!cpu_block_bit_i || ctrl_sh[9])) |-> ##[1:3] irq_valid_o && irq_nmi_o)
        else $error("nmi edge not raised");
    a_wake_low: assert property (standby_i && ctrl_sh[14] && !nmi_pin_i |=> !wake_o)
        else $error("wake with pin low");
    a_pin_mode: assert property (reg_wr_i && reg_addr_i == pinc_pkg::ADDR_CTRL |=> ##1 request_pin_mode_o == $past(ctrl_sh[7]))
        else $error("pin mode copy wrong");
endmodule : pinc_top_sva
bind pinc_top pinc_top_sva u_sva (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .nmi_pin_i, .src_req_i, .cpu_mask_level_i, .cpu_block_bit_i,
    .standby_i, .cpu_accept_i, .irq_valid_o, .irq_nmi_o, .irq_level_o, .irq_code_o,
    .request_pin_mode_o, .wake_o);

// ==== verification/test_pinc_top.sv ====
// Self-checking bench for the interrupt priority block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module test_pinc_top;
    logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, nmi_pin_i = 1'b1;
    logic cpu_block_bit_i = 1'b0, standby_i = 1'b0, rd_seen = 1'b0, cpu_accept_i;
    logic [3:0] reg_addr_i = 4'h0, cpu_mask_level_i = 4'h0, wait_q = 4'h0, lv, irq_level_o;
    logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o;
    logic [13:0] src_req_i = 14'h0;
    logic irq_valid_o, irq_nmi_o, request_pin_mode_o, wake_o;
    logic [11:0] irq_code_o;
    logic [15:0] rd_q[$], irq_q[$], exp_v;
    logic [19:0] f;
    logic [31:0] seed = 32'd14801;
    int failures = 0, checks = 0, cycles = 0, i;
    logic [11:0] codes [14] = '{12'h480, 12'h4a0, 12'h4c0, 12'h4e0, 12'h500, 12'h520, 12'h540,
        12'h700, 12'h720, 12'h740, 12'h760, 12'h560, 12'h580, 12'h5a0};
    pinc_top uut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .nmi_pin_i, .src_req_i, .cpu_mask_level_i, .cpu_block_bit_i, .standby_i, .cpu_accept_i,
        .irq_valid_o, .irq_nmi_o, .irq_level_o, .irq_code_o, .request_pin_mode_o, .wake_o);
    pinc_cpu_model cpu (.clk_i, .rst_n_i, .valid_i(irq_valid_o), .wait_i(wait_q),
        .accept_o(cpu_accept_i));
    always #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Register index and field value holding the level of source s
    function automatic logic [19:0] fld(int s, logic [3:0] l);
        if (s < 3) return {4'h0, 16'(l)};
        if (s < 11) return {(s < 7) ? 4'h1 : 4'h2, 16'(l) << 4};
        return {4'h1, 16'(l) << ((s == 11) ? 12 : 8)};
    endfunction : fld
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge clk_i);
        rd_q.push_back(e);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    // Note the expected group, wait for the accept, withdraw source s
    task automatic take(logic [15:0] e, int s);
        int n;
        n = 0;
        irq_q.push_back(e);
        wait_q <= 4'(rnd() % 4);
        do begin
            @(posedge clk_i);
            n++;
        end while (!(cpu_accept_i && irq_valid_o) && n < 60);
        src_req_i <= src_req_i & ~(14'h1 << s);
        `CHK(n < 60, 1'b1)
    endtask : take
    task automatic quiet();
        repeat (6) @(posedge clk_i);
        `CHK(irq_valid_o, 1'b0)
    endtask : quiet
    // Compare read data and accepted groups against the oldest notes
    always @(posedge clk_i) begin
        if (rd_seen) begin
            exp_v = rd_q.pop_front();
            `CHK(reg_rdata_o, exp_v)
        end
        if (cpu_accept_i && irq_valid_o) begin
            exp_v = irq_q.pop_front();
            `CHK({irq_level_o, irq_code_o}, exp_v)
        end
        rd_seen <= reg_rd_i;
        cycles++;
        if (cycles > 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 7; i++) rd(4'(i), (i == 3) ? 16'h8000 : 16'h0000);
        for (i = 0; i < 4; i++) wr(4'(i), 16'hffff);
        rd(4'h0, 16'hffff);
        rd(4'h1, 16'hfff0);
        rd(4'h2, 16'hffff);
        rd(4'h3, 16'hc380);
        `CHK(request_pin_mode_o, 1'b1)
        nmi_pin_i <= 1'b0;
        src_req_i <= 14'h0800;
        quiet();
        src_req_i <= 14'h0;
        standby_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(wake_o, 1'b0)
        standby_i <= 1'b0;
        nmi_pin_i <= 1'b1;
        take({4'hf, 12'h1c0}, 14);
        rd(4'h3, 16'hc180);
        wr(4'h3, 16'h0000);
        cpu_block_bit_i <= 1'b1;
        nmi_pin_i <= 1'b0;
        quiet();
        rd(4'h5, 16'h0001);
        standby_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK(wake_o, 1'b1)
        standby_i <= 1'b0;
        rd(4'h4, 16'h01c0);
        wr(4'h3, 16'h0200);
        take({4'hf, 12'h1c0}, 14);
        rd(4'h3, 16'h0000);
        `CHK(request_pin_mode_o, 1'b0)
        cpu_block_bit_i <= 1'b0;
        nmi_pin_i <= 1'b1;
        for (i = 0; i < 14; i++) begin
            lv = 4'(rnd() % 15) + 4'h1;
            f = fld(i, lv);
            wr(f[19:16], f[15:0]);
            cpu_mask_level_i <= lv - 4'h1;
            src_req_i <= 14'h1 << i;
            take({lv, codes[i]}, i);
            rd(4'h4, {4'h0, codes[i]});
        end
        wr(4'h1, 16'h3000);
        cpu_mask_level_i <= 4'h3;
        src_req_i <= 14'h0800;
        quiet();
        cpu_mask_level_i <= 4'h2;
        take({4'h3, 12'h560}, 11);
        wr(4'h1, 16'h0000);
        cpu_mask_level_i <= 4'h0;
        src_req_i <= 14'h0800;
        quiet();
        src_req_i <= 14'h0;
        wr(4'h0, 16'h0005);
        wr(4'h1, 16'h5550);
        wr(4'h2, 16'h0050);
        src_req_i <= 14'h3fff;
        for (i = 0; i < 14; i++) take({4'h5, codes[i]}, i);
        repeat (4) @(posedge clk_i);
        stop_test();
    end
endmodule : test_pinc_top
